/* rtl/adcp_ctrl_port.v */
/*
 Two-wire serial control port slave of an audio processor: address match,
 subaddressed writes, seven-byte readback and clock-stretch wait states.
 Assumes open-drain SCL/SDA resolved outside; both pins arrive asynchronous
 and are double-flopped onto clk_sys. The EPROM boot master lives elsewhere;
 this block only releases the bus to it via boot_done.
*/
// Overview of operation
// - Slave address is 011010 plus the address-select pin level.
// - Answer 0x68/0x69 with select low, 0x6A/0x6B with select high.
// - First byte after write address is subaddress, steering later data bytes.
// - Receiver acknowledges every byte; device pulls SDA low on its ack clock.
// - Any number of bytes accepted between start and stop.
// - The last seven received bytes stay in a FIFO readback buffer.
// - Reads return oldest byte first, next on each master ack, stop ends.
// - Volume or tone change stalls the next command 41 to 231 ms.
// - Long command series may cause short waits of 150 to 300 us.
// - At 32 kHz, occasional waits of up to 15 ms.
// - Volume wait is 62, 49 or 41 ms at 32, 44.1, 48 kHz.
// - Tone wait scales with change, full range 231, 167 or 153 ms.
// - Equalizer waits 15 ms, 190 us, 300 us; compression 300 us; others none.
// - Port runs standard mode, up to 100 kbps.
// - Byte, word and block SMBus transfers work; no negative acknowledge.
// - Try EPROM load as master first, then fall back to slave operation.
// - SMBus read returns last subaddress then last six data bytes; code returns the last seven received bytes.
// - The EPROM is addressed at bus address A0h.
`timescale 1ns/1ps
`include "adcp_map.vh"
module adcp_ctrl_port #(
   parameter LOAD_BURST = 16,                         // Bytes between short load pauses.
   parameter WAIT_W     = 24                          // Wait counter width.
) (
   input  wire       clk_sys,                         // System clock, 50 MHz.
   input  wire       reset_n,                         // Synchronous reset, active low.
   input  wire       address_select_pin,              // Low address bit strap.
   input  wire [1:0] fs_sel,                          // Sample rate: 0 32k, 1 44.1k, 2 48k.
   input  wire       boot_done,                       // EPROM load attempt finished.
   input  wire       scl_in,                          // Serial clock pin level.
   output wire       scl_out,                         // Serial clock drive value (low).
   output reg        scl_oe,                          // Serial clock pulled low when high.
   input  wire       sda_in,                          // Serial data pin level.
   output wire       sda_out,                         // Serial data drive value (low).
   output reg        sda_oe,                          // Serial data pulled low when high.
   output reg  [7:0] wr_sub,                          // Subaddress of the current write.
   output reg  [7:0] wr_data,                         // Data byte delivered to storage.
   output reg  [7:0] wr_index,                        // Byte position within the subaddress.
   output reg        wr_strobe,                       // One-cycle pulse per data byte.
   output wire       busy                             // Wait state in progress.
);
   // Cycle counts per microsecond-based time, derived from the clock rate.
   // The products are worked out as integers and then cut to the counter width
   // on purpose; WAIT_W must hold the longest tone wait, 231 ms at 32 kHz.
   localparam integer VOL32_N    = `ADCP_VOL_WAIT_US_32 * `ADCP_CLK_MHZ;
   localparam integer VOL44_N    = `ADCP_VOL_WAIT_US_44 * `ADCP_CLK_MHZ;
   localparam integer VOL48_N    = `ADCP_VOL_WAIT_US_48 * `ADCP_CLK_MHZ;
   localparam integer TONE32_N   = `ADCP_TONE_WAIT_US_32 * `ADCP_CLK_MHZ;
   localparam integer TONE44_N   = `ADCP_TONE_WAIT_US_44 * `ADCP_CLK_MHZ;
   localparam integer TONE48_N   = `ADCP_TONE_WAIT_US_48 * `ADCP_CLK_MHZ;
   localparam integer EQ32_N     = `ADCP_EQ_WAIT_US_32 * `ADCP_CLK_MHZ;
   localparam integer EQ44_N     = `ADCP_EQ_WAIT_US_44 * `ADCP_CLK_MHZ;
   localparam integer EQ48_N     = `ADCP_EQ_WAIT_US_48 * `ADCP_CLK_MHZ;
   localparam integer DRC_N      = `ADCP_DRC_WAIT_US * `ADCP_CLK_MHZ;
   localparam integer LOAD_N     = `ADCP_LOAD_WAIT_US * `ADCP_CLK_MHZ;
   localparam integer TONE_DIV_N = `ADCP_TONE_STEPS;
   localparam [WAIT_W-1:0] CYC_VOL32  = VOL32_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_VOL44  = VOL44_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_VOL48  = VOL48_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_TONE32 = TONE32_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_TONE44 = TONE44_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_TONE48 = TONE48_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_EQ32   = EQ32_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_EQ44   = EQ44_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_EQ48   = EQ48_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_DRC    = DRC_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] CYC_LOAD   = LOAD_N[WAIT_W-1:0];
   localparam [WAIT_W-1:0] TONE_DIV   = TONE_DIV_N[WAIT_W-1:0];

   // Byte engine states.
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_RX   = 3'h2;
   localparam [2:0] ST_RACK = 3'h3;
   localparam [2:0] ST_TX   = 3'h4;
   localparam [2:0] ST_TACK = 3'h5;
   localparam [2:0] ST_SKIP = 3'h6;

   // Wait time for a write to one subaddress; zero means no stall.
   function [WAIT_W-1:0] wait_for;
      input [7:0] sub;
      input [1:0] fs;
      input [7:0] step;
      reg   [WAIT_W-1:0] full;
      begin
         full = (fs == `ADCP_FS_32K) ? CYC_TONE32 : (fs == `ADCP_FS_44K) ? CYC_TONE44 : CYC_TONE48;
         if (sub == `ADCP_SUB_VOLUME) begin
            wait_for = (fs == `ADCP_FS_32K) ? CYC_VOL32 : (fs == `ADCP_FS_44K) ? CYC_VOL44 : CYC_VOL48;
         end else if (sub == `ADCP_SUB_BASS || sub == `ADCP_SUB_TREBLE) begin
            wait_for = (step >= `ADCP_TONE_STEPS) ? full :
                       (full / TONE_DIV) * step[4:0];
         end else if (sub >= `ADCP_SUB_EQ_LO && sub <= `ADCP_SUB_EQ_HI) begin
            wait_for = (fs == `ADCP_FS_32K) ? CYC_EQ32 : (fs == `ADCP_FS_44K) ? CYC_EQ44 : CYC_EQ48;
         end else if (sub == `ADCP_SUB_DRC) begin
            wait_for = CYC_DRC;
         end else begin
            wait_for = {WAIT_W{1'b0}};
         end
      end
   endfunction

   // Pin synchronisers; only the second and third stages are looked at.
   // The address strap is a pin too, so it is synchronised the same way; it is
   // only read at the end of an address byte, so the two-cycle lag never shows.
   reg        scl_m_r, scl_s_r, scl_d_r;
   reg        sda_m_r, sda_s_r, sda_d_r;
   reg        addr_sel_m_r, addr_sel_s_r;
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         scl_m_r      <= 1'b1;
         scl_s_r      <= 1'b1;
         scl_d_r      <= 1'b1;
         sda_m_r      <= 1'b1;
         sda_s_r      <= 1'b1;
         sda_d_r      <= 1'b1;
         addr_sel_m_r <= 1'b0;
         addr_sel_s_r <= 1'b0;
      end else begin
         scl_m_r      <= scl_in;
         scl_s_r      <= scl_m_r;
         scl_d_r      <= scl_s_r;
         sda_m_r      <= sda_in;
         sda_s_r      <= sda_m_r;
         sda_d_r      <= sda_s_r;
         addr_sel_m_r <= address_select_pin;
         addr_sel_s_r <= addr_sel_m_r;
      end
   end

   // Edges and bus conditions come from the synchronised copies only; start and
   // stop need SCL high in both stages, so a data change at an SCL fall is safe.
   wire scl_rise = scl_s_r & ~scl_d_r;
   wire scl_fall = ~scl_s_r & scl_d_r;
   wire start_c  = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   wire stop_c   = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

   // Byte engine state, readback storage and wait bookkeeping.
   reg  [2:0]        state_r;
   reg  [3:0]        bit_r;
   reg  [7:0]        shift_r;
   reg               rnw_r;
   reg               have_sub_r;
   reg  [7:0]        rb_mem [0:`ADCP_RB_DEPTH-1];
   reg  [2:0]        rb_rd_r;
   reg  [7:0]        tone_old_r;
   reg  [WAIT_W-1:0] wait_r;
   reg  [WAIT_W-1:0] pend_r;
   reg  [7:0]        burst_r;
   reg               stretch_r;
   wire [7:0]        step = (shift_r > tone_old_r) ? shift_r - tone_old_r : tone_old_r - shift_r;
   wire [7:0]        my_addr = {1'b0, `ADCP_ADDR_HI, addr_sel_s_r};

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign busy    = (wait_r != {WAIT_W{1'b0}});

   // One push per received byte, on the SCL fall that ends its eighth bit. The
   // subaddress byte is pushed as well, so a read shows it ahead of the data until a seventh data byte follows.
   wire   rb_push = boot_done & ~stop_c & ~start_c & scl_fall &
                    (state_r == ST_RX) & (bit_r == 4'h8);

   // Readback buffer shifts: newest enters at the top, oldest falls out. Kept
   // as a shift register so no pointer math can desynchronise after overflow.
   genvar gi;
   generate
      for (gi = 0; gi < `ADCP_RB_DEPTH; gi = gi + 1) begin : g_rb
         always @(posedge clk_sys) begin
            if (!reset_n) begin
               rb_mem[gi] <= 8'h00;
            end else if (rb_push) begin
               rb_mem[gi] <= (gi == `ADCP_RB_DEPTH-1) ? shift_r : rb_mem[(gi+1) % `ADCP_RB_DEPTH];
            end
         end
      end
   endgenerate

   // Byte engine: address match, receive, acknowledge, transmit.
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         state_r    <= ST_IDLE;
         bit_r      <= 4'h0;
         shift_r    <= 8'h00;
         rnw_r      <= 1'b0;
         have_sub_r <= 1'b0;
         rb_rd_r    <= 3'h0;
         sda_oe     <= 1'b0;
         wr_sub     <= 8'h00;
         wr_data    <= 8'h00;
         wr_index   <= 8'h00;
         wr_strobe  <= 1'b0;
         tone_old_r <= 8'h00;
         pend_r     <= {WAIT_W{1'b0}};
         burst_r    <= 8'h00;
      end else begin
         wr_strobe <= 1'b0;
         if (!boot_done) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
         end else if (stop_c) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
            if (!busy) begin
               pend_r <= {WAIT_W{1'b0}};
            end
         end else if (start_c) begin
            state_r <= ST_ADDR;
            bit_r   <= 4'h0;
            sda_oe  <= 1'b0;
         end else begin
            case (state_r)
               ST_ADDR, ST_RX: begin
                  if (scl_rise && bit_r != 4'h8) begin
                     shift_r <= {shift_r[6:0], sda_s_r};
                     bit_r   <= bit_r + 4'h1;
                  end else if (scl_fall && bit_r == 4'h8) begin
                     if (state_r == ST_ADDR) begin
                        if (shift_r[7:1] == my_addr[6:0]) begin
                           rnw_r      <= shift_r[0];
                           have_sub_r <= 1'b0;
                           rb_rd_r    <= 3'h0;
                           sda_oe     <= 1'b1;
                           state_r    <= ST_RACK;
                        end else begin
                           state_r <= ST_SKIP;
                        end
                     end else begin
                        sda_oe  <= 1'b1;
                        state_r <= ST_RACK;
                        if (!have_sub_r) begin
                           have_sub_r <= 1'b1;
                           wr_sub     <= shift_r;
                           wr_index   <= 8'h00;
                        end else begin
                           wr_data   <= shift_r;
                           wr_strobe <= 1'b1;
                           wr_index  <= wr_index + 8'h01;
                           burst_r   <= burst_r + 8'h01;
                           if (wr_sub == `ADCP_SUB_BASS || wr_sub == `ADCP_SUB_TREBLE) begin
                              tone_old_r <= shift_r;
                           end
                           if (wait_for(wr_sub, fs_sel, step) != {WAIT_W{1'b0}}) begin
                              pend_r <= wait_for(wr_sub, fs_sel, step);
                           end else if (burst_r == LOAD_BURST[7:0]) begin
                              pend_r  <= CYC_LOAD;
                              burst_r <= 8'h00;
                           end
                        end
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     bit_r  <= 4'h0;
                     if (rnw_r) begin
                        sda_oe  <= ~rb_mem[0][7];
                        shift_r <= {rb_mem[0][6:0], 1'b0};
                        rb_rd_r <= 3'h1;
                        state_r <= ST_TX;
                     end else begin
                        state_r <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_r == 4'h7) begin
                        sda_oe  <= 1'b0;
                        state_r <= ST_TACK;
                     end else begin
                        sda_oe  <= ~shift_r[7];
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_r   <= bit_r + 4'h1;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     if (!sda_s_r && rb_rd_r < `ADCP_RB_DEPTH) begin
                        bit_r   <= 4'h8;
                     end else begin
                        state_r <= ST_SKIP;
                     end
                  end else if (scl_fall && bit_r == 4'h8) begin
                     sda_oe  <= ~rb_mem[rb_rd_r][7];
                     shift_r <= {rb_mem[rb_rd_r][6:0], 1'b0};
                     rb_rd_r <= rb_rd_r + 3'h1;
                     bit_r   <= 4'h0;
                     state_r <= ST_TX;
                  end
               end
               ST_IDLE, ST_SKIP: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Wait-state timer: armed by a write, it stretches SCL low after the next
   // acknowledge until the interpolation completes. The pending time is handed
   // over at the stop and cleared by the byte engine in that same cycle, so one
   // write arms exactly one wait.
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         wait_r    <= {WAIT_W{1'b0}};
         stretch_r <= 1'b0;
      end else begin
         if (stop_c && pend_r != {WAIT_W{1'b0}} && wait_r == {WAIT_W{1'b0}}) begin
            wait_r <= pend_r;
         end else if (wait_r != {WAIT_W{1'b0}}) begin
            wait_r <= wait_r - {{(WAIT_W-1){1'b0}}, 1'b1};
         end
         stretch_r <= busy & (state_r == ST_RACK) & scl_fall;
      end
   end

   // SCL is held low once the ack clock ends while busy, released when idle.
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         scl_oe <= 1'b0;
      end else if (stretch_r || (scl_oe && busy)) begin
         scl_oe <= 1'b1;
      end else begin
         scl_oe <= 1'b0;
      end
   end
endmodule // adcp_ctrl_port

/* shared/adcp_map.vh */
/*
 Constants for the two-wire control port: address pattern, subaddresses,
 byte counts and wait-state times. Included by rtl/adcp_ctrl_port.v.
*/
`ifndef ADCP_MAP_VH
`define ADCP_MAP_VH
`define ADCP_ADDR_HI        6'h1A
`define ADCP_EPROM_ADDR     7'h50
`define ADCP_SUB_VOLUME     8'h04
`define ADCP_SUB_BASS       8'h06
`define ADCP_SUB_TREBLE     8'h05
`define ADCP_SUB_DRC        8'h02
`define ADCP_SUB_EQ_LO      8'h0A
`define ADCP_SUB_EQ_HI      8'h17
`define ADCP_RB_DEPTH       7
`define ADCP_CLK_MHZ        50
`define ADCP_VOL_WAIT_US_32 62000
`define ADCP_VOL_WAIT_US_44 49000
`define ADCP_VOL_WAIT_US_48 41000
`define ADCP_TONE_WAIT_US_32 231000
`define ADCP_TONE_WAIT_US_44 167000
`define ADCP_TONE_WAIT_US_48 153000
`define ADCP_EQ_WAIT_US_32  15000
`define ADCP_EQ_WAIT_US_44  190
`define ADCP_EQ_WAIT_US_48  300
`define ADCP_DRC_WAIT_US    300
`define ADCP_LOAD_WAIT_US   150
`define ADCP_TONE_STEPS     18
`define ADCP_FS_32K         2'h0
`define ADCP_FS_44K         2'h1
`define ADCP_FS_48K         2'h2
`endif

/* verification/adcp_chk_monitor.sv */
/* Checker for the control port slave: pin drive, acks, strobes, waits.
   Assumes a bind onto adcp_ctrl_port, one clock domain, sync reset. */
`timescale 1ns/1ps
module adcp_chk (
   input wire logic clk_sys,   // System clock.
   input wire logic reset_n,   // Reset, active low.
   input wire logic boot_done, // Boot load attempt over.
   input wire logic scl_in,    // Clock wire level.
   input wire logic sda_in,    // Data wire level.
   input wire logic scl_out,   // Clock drive value.
   input wire logic sda_out,   // Data drive value.
   input wire logic scl_oe,    // Clock pull enable.
   input wire logic sda_oe,    // Data pull enable.
   input wire logic wr_strobe, // Data byte pulse.
   input wire logic busy       // Wait state running.
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Open-drain pins may only pull low, never drive high.
   pull_only_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("pin drive value not low");
   strobe_pulse_a: assert property (wr_strobe |=> !wr_strobe)
      else $error("strobe longer than one cycle");
   strobe_ack_a: assert property (wr_strobe |-> ##[0:8] sda_oe)
      else $error("data byte not acknowledged");
   ack_stand_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
      else $error("data pull too short");
   // The bus stays untouched until the boot attempt is over.
   boot_quiet_a: assert property (!boot_done |-> !sda_oe && !scl_oe)
      else $error("bus driven before boot done");
   stretch_busy_a: assert property ($rose(scl_oe) |-> busy)
      else $error("clock held without wait");
   stretch_end_a: assert property ($fell(busy) |-> ##[0:3] !scl_oe)
      else $error("clock held after wait");
   wait_stop_a: assert property ($rose(busy) |-> scl_in && sda_in)
      else $error("wait began outside stop");
   wait_floor_a: assert property ($rose(busy) |=> busy [*8])
      else $error("wait state too short");
   cover property (wr_strobe);
   cover property ($rose(scl_oe));
   cover property ($fell(busy));
endmodule // adcp_chk
bind adcp_ctrl_port adcp_chk adcp_chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .boot_done(boot_done),
   .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .sda_out(sda_out), .scl_oe(scl_oe),
   .sda_oe(sda_oe), .wr_strobe(wr_strobe), .busy(busy));

/* verification/adcp_host_model.sv */
/* Behavioural two-wire bus master, 8 system clocks per bit.
   Assumes wired-AND wires with pull-ups resolved by the bench. */
`timescale 1ns/1ps
module adcp_host_model (
   input  wire logic clk_sys,    // Time base.
   input  wire logic scl_in,     // Resolved clock wire.
   input  wire logic sda_in,     // Resolved data wire.
   output logic      scl_pull_r, // Pull clock low.
   output logic      sda_pull_r  // Pull data low.
);
   int stretch_n = 0;
   initial begin
      scl_pull_r = 1'b0;
      sda_pull_r = 1'b0;
   end
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Release the clock and wait out any stretch; bounded so a stuck slave cannot hang us.
   task rise;
      int n;
      scl_pull_r <= 1'b0;
      n = 0;
      tick(1);
      while (scl_in !== 1'b1 && n < 20000) begin
         tick(1);
         n++;
      end
      stretch_n += n;
      tick(3);
   endtask
   task bit_w(input logic b);
      tick(1);
      sda_pull_r <= !b;
      tick(3);
      rise();
      scl_pull_r <= 1'b1;
   endtask
   // Data is sampled just before the fall, where the slave holds it.
   task bit_r(output logic b);
      tick(1);
      sda_pull_r <= 1'b0;
      tick(3);
      rise();
      b = sda_in;
      scl_pull_r <= 1'b1;
   endtask
   task start_c;
      tick(1);
      sda_pull_r <= 1'b1;
      tick(4);
      scl_pull_r <= 1'b1;
   endtask
   task stop_c;
      tick(1);
      sda_pull_r <= 1'b1;
      tick(3);
      rise();
      sda_pull_r <= 1'b0;
      tick(4);
   endtask
   task byte_w(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bit_w(d[i]);
      bit_r(b);
      ack = !b;
   endtask
   task byte_r(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) bit_r(d[i]);
      bit_w(last);
   endtask
endmodule // adcp_host_model

/* verification/adcp_tb.sv */
/* Self-checking bench for the control port slave.
   Assumes the host model as far side and pull-ups on both wires. */
`timescale 1ns/1ps
`include "adcp_map.vh"
module tb;
   logic       clk_sys, reset_n, address_select_pin, boot_done, ack;
   logic [1:0] fs_sel;
   logic [7:0] rd;
   wire        scl_w, sda_w, scl_out, scl_oe, sda_out, sda_oe, wr_strobe, busy, scl_pull, sda_pull;
   wire  [7:0] wr_sub, wr_data, wr_index;
   logic [7:0] s_sub[$], s_dat[$], s_idx[$];
   int         failures = 0, cmp_count = 0, busy_len = 0;
   localparam int WT = `ADCP_EQ_WAIT_US_44 * `ADCP_CLK_MHZ;
   // Wired-AND: any party pulling low wins over the pull-up.
   assign scl_w = ~(scl_pull | scl_oe);
   assign sda_w = ~(sda_pull | sda_oe);
   adcp_ctrl_port adcp_ctrl_port_i (.clk_sys(clk_sys), .reset_n(reset_n), .address_select_pin(address_select_pin),
      .fs_sel(fs_sel), .boot_done(boot_done), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .wr_sub(wr_sub), .wr_data(wr_data),
      .wr_index(wr_index), .wr_strobe(wr_strobe), .busy(busy));
   adcp_host_model adcp_host_model_i (.clk_sys(clk_sys), .scl_in(scl_w), .sda_in(sda_w),
      .scl_pull_r(scl_pull), .sda_pull_r(sda_pull));
   initial clk_sys = 1'b0;
   always #10 clk_sys = ~clk_sys;
   // Record every delivered byte and every busy cycle.
   always @(posedge clk_sys) begin
      if (wr_strobe === 1'b1) begin
         s_sub.push_back(wr_sub);
         s_dat.push_back(wr_data);
         s_idx.push_back(wr_index);
      end
      if (busy === 1'b1) busy_len++;
   end
   function automatic logic [7:0] pat(input int i);
      pat = 8'h3C ^ (8'h11 * i[7:0]);
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task wr_byte(input logic [7:0] d);
      adcp_host_model_i.byte_w(d, ack);
   endtask
   task t_boot;
      adcp_host_model_i.start_c();
      wr_byte(8'h68);
      adcp_host_model_i.stop_c();
      chk(ack, 1'b0);
      @(posedge clk_sys) boot_done <= 1'b1;
      repeat (4) @(posedge clk_sys);
      $display("test boot done");
   endtask
   task t_addr;
      logic [7:0] a;
      for (int s = 0; s < 2; s++) for (int k = 0; k < 4; k++) begin
         a = 8'h68 + {k[1:0], 1'b0};
         @(posedge clk_sys) address_select_pin <= s[0];
         adcp_host_model_i.start_c();
         wr_byte(a);
         adcp_host_model_i.stop_c();
         chk(ack, a[7:1] == {`ADCP_ADDR_HI, s[0]});
      end
      @(posedge clk_sys) address_select_pin <= 1'b0;
      $display("test address done");
   endtask
   task t_wr;
      adcp_host_model_i.start_c();
      wr_byte(8'h68);
      chk(ack, 1'b1);
      wr_byte(8'h07);
      for (int i = 0; i < 8; i++) begin
         wr_byte(pat(i));
         chk(ack, 1'b1);
      end
      adcp_host_model_i.stop_c();
      chk(s_dat.size(), 8);
      for (int i = 0; i < 8; i++) begin
         chk(s_sub[i], 8'h07);
         chk(s_dat[i], pat(i));
         chk(s_idx[i], i + 1);
      end
      $display("test write done");
   endtask
   // Nine bytes went in, so the oldest two are gone and readback starts at data byte 1.
   task t_rd;
      adcp_host_model_i.start_c();
      wr_byte(8'h69);
      chk(ack, 1'b1);
      for (int i = 0; i < 7; i++) begin
         adcp_host_model_i.byte_r(i == 6, rd);
         chk(rd, pat(i + 1));
      end
      adcp_host_model_i.stop_c();
      $display("test readback done");
   endtask
   task t_wait;
      @(posedge clk_sys) fs_sel <= `ADCP_FS_44K;
      adcp_host_model_i.start_c();
      wr_byte(8'h68);
      wr_byte(`ADCP_SUB_EQ_LO);
      wr_byte(8'h5A);
      busy_len = 0;
      adcp_host_model_i.stop_c();
      adcp_host_model_i.stretch_n = 0;
      adcp_host_model_i.start_c();
      wr_byte(8'h68);
      chk(ack, 1'b1);
      wr_byte(8'h07);
      adcp_host_model_i.stop_c();
      chk(busy_len >= WT - 4 && busy_len <= WT + 4, 1'b1);
      chk(adcp_host_model_i.stretch_n > WT - 400, 1'b1);
      chk(s_sub[8], `ADCP_SUB_EQ_LO);
      $display("test wait done");
   endtask
   task give_verdict;
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard: the tests need about 12000 cycles.
   initial begin
      repeat (60000) @(posedge clk_sys);
      failures++;
      give_verdict();
   end
   initial begin
      reset_n = 1'b0;
      boot_done = 1'b0;
      address_select_pin = 1'b0;
      fs_sel = `ADCP_FS_48K;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_boot();
      t_addr();
      t_wr();
      t_rd();
      t_wait();
      give_verdict();
   end
endmodule // tb
